// >>> include/legacy_cmd_cfg.svh
// Functional notes
// - status bits 7,3,2,1 always read zero
// - bit 6 set on request, cleared by clear/poll
// - bit 5 set on error, cleared after query response
// - bit 4 ready, cleared when execute received
// - bit 0 follows overload condition
// - status byte readable only by serial poll
// - service request only on parallel bus
// - one letter header, zero to two parameters
// - missing parameters take header defaults
// - buffer commands until execute arrives
// - execute by fixed priority, high to low
// - any receive error discards whole batch; exec_error only sets bit 5
// - legacy set only when selected, never both
// - listed headers supported, others unavailable
// - hold-off keeps not-ready until batch done
// - end-or-identify ignored on reception
`ifndef LEGACY_CMD_CFG_SVH
`define LEGACY_CMD_CFG_SVH

`define SB_SREQ_BIT    6
`define SB_ERR_BIT     5
`define SB_RDY_BIT     4
`define SB_OVL_BIT     0

`define CHR_A          8'h41
`define CHR_C          8'h43
`define CHR_I          8'h49
`define CHR_K          8'h4B
`define CHR_L          8'h4C
`define CHR_M          8'h4D
`define CHR_N          8'h4E
`define CHR_P          8'h50
`define CHR_R          8'h52
`define CHR_S          8'h53
`define CHR_T          8'h54
`define CHR_U          8'h55
`define CHR_X          8'h58
`define CHR_Y          8'h59
`define CHR_Z          8'h5A
`define CHR_UP_FIRST   8'h41
`define CHR_UP_LAST    8'h5A
`define CHR_DIG_FIRST  8'h30
`define CHR_DIG_LAST   8'h39
`define CHR_SPACE      8'h20
`define CHR_CR         8'h0D
`define CHR_LF         8'h0A
`define CHR_COMMA      8'h2C

`define DEF_A          4'h1
`define DEF_C          4'h1
`define DEF_I          4'h0
`define DEF_K          4'h0
`define DEF_OTHER      4'h0
`define PARAM_MAX      2'h2
`define N_AUTO_PARAM   4'h2
`define U_ERR_PARAM    4'h1
`define K_HOLDOFF_MAX  4'h1

`define PRIO_FIRST     4'h1
`define PRIO_LAST      4'hF

`endif

// >>> include/legacy_cmd_pkg.sv
package legacy_cmd_pkg;
    typedef enum logic [3:0] {
        HDR_M = 4'h0, HDR_K = 4'h1, HDR_A = 4'h2, HDR_I = 4'h3,
        HDR_R = 4'h4, HDR_T = 4'h5, HDR_P = 4'h6, HDR_Z = 4'h7,
        HDR_S = 4'h8, HDR_N = 4'h9, HDR_C = 4'hA, HDR_Y = 4'hB,
        HDR_U = 4'hC, HDR_L = 4'hD, HDR_X = 4'hE, HDR_BAD = 4'hF
    } hdr_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } exec_state_type;
endpackage

// >>> design/cmd_batch_buffer.sv
`timescale 1ns/1ps
// arrival-ordered store of parsed commands, read by index
module cmd_batch_buffer #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 14,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             flush,
    input  wire logic [AW-1:0]    rd_idx,
    output logic      [WIDTH-1:0] rd_data,
    output logic      [AW:0]      count,
    output logic                  full
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;

    // flush wins; a write to a full store is dropped (caller flags it)
    always_comb begin
        count_nxt = count_r;
        if (flush) begin
            count_nxt = '0;
        end else if (wr_en && !full) begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // storage needs no reset; count guards every read
    always_ff @(posedge clock) begin
        if (wr_en && !full && !flush) begin
            mem_r[count_r[AW-1:0]] <= wr_data;
        end
    end

    assign rd_data = mem_r[rd_idx];
    assign count   = count_r;
    assign full    = (count_r == (AW+1)'(DEPTH));
endmodule

// >>> design/legacy_command_status_unit.sv
`timescale 1ns/1ps
`include "legacy_cmd_cfg.svh"
module legacy_command_status_unit
    import legacy_cmd_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       legacy_sel,
    input  wire logic       rx_valid,
    output logic            rx_ready,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_eoi,
    output logic            nrfd_hold,
    input  wire logic       spoll_req,
    output logic [7:0]      spoll_data,
    input  wire logic       dev_clear,
    input  wire logic       srq_event,
    output logic            srq_line,
    input  wire logic       exec_error,
    input  wire logic       query_resp_done,
    input  wire logic       overload,
    output logic            exec_valid,
    output hdr_type         exec_hdr,
    output logic [3:0]      exec_param0,
    output logic [3:0]      exec_param1,
    output logic [1:0]      exec_count,
    output logic            eoi_append,
    output logic            busy
);
    localparam int AW = $clog2(DEPTH);
    localparam int EW = 14;

    // entry layout: hdr[13:10] count[9:8] p0[7:4] p1[3:0]
    logic           pend_r,  pend_nxt;
    hdr_type        phdr_r,  phdr_nxt;
    logic [1:0]     pnp_r,   pnp_nxt;
    logic [3:0]     pp0_r,   pp0_nxt;
    logic [3:0]     pp1_r,   pp1_nxt;
    logic           berr_r,  berr_nxt;
    exec_state_type st_r,    st_nxt;
    logic [3:0]     prio_r,  prio_nxt;
    logic [AW-1:0]  idx_r,   idx_nxt;
    logic           ev_r,    ev_nxt;
    hdr_type        eh_r,    eh_nxt;
    logic [3:0]     e0_r,    e0_nxt;
    logic [3:0]     e1_r,    e1_nxt;
    logic [1:0]     ec_r,    ec_nxt;
    logic           hold_r,  hold_nxt;
    logic           eoi_r,   eoi_nxt;
    logic           uq_r,    uq_nxt;
    logic           sreq_r,  sreq_nxt;
    logic           err_r,   err_nxt;
    logic           rdy_r,   rdy_nxt;
    logic [7:0]     sp_r,    sp_nxt;

    logic           wr_en;
    logic           flush;
    logic [EW-1:0]  rd_data;
    logic [AW:0]    count;
    logic           full;
    logic           take;
    hdr_type        dec_hdr;
    hdr_type        rd_hdr;
    logic [1:0]     rd_np;
    logic [3:0]     rd_p0;
    logic [3:0]     rd_p1;
    logic           last_idx;

    cmd_batch_buffer #(.DEPTH(DEPTH), .WIDTH(EW)) cmd_batch_buffer_inst (
        .clock   (clock),
        .rstn    (rstn),
        .wr_en   (wr_en),
        .wr_data ({phdr_r, pnp_r, pp0_r, pp1_r}),
        .flush   (flush),
        .rd_idx  (idx_r),
        .rd_data (rd_data),
        .count   (count),
        .full    (full)
    );

    // headers of removed functions decode as unavailable
    function automatic hdr_type decode(input logic [7:0] c);
        unique case (c)
            `CHR_M:  decode = HDR_M;
            `CHR_K:  decode = HDR_K;
            `CHR_A:  decode = HDR_A;
            `CHR_I:  decode = HDR_I;
            `CHR_R:  decode = HDR_R;
            `CHR_T:  decode = HDR_T;
            `CHR_P:  decode = HDR_P;
            `CHR_Z:  decode = HDR_Z;
            `CHR_S:  decode = HDR_S;
            `CHR_N:  decode = HDR_N;
            `CHR_C:  decode = HDR_C;
            `CHR_Y:  decode = HDR_Y;
            `CHR_U:  decode = HDR_U;
            `CHR_L:  decode = HDR_L;
            `CHR_X:  decode = HDR_X;
            default: decode = HDR_BAD;
        endcase
    endfunction

    // N splits into two ranks by parameter: on/off versus auto run
    function automatic logic [3:0] prio_of(input hdr_type h,
                                           input logic [3:0] p0);
        if (h == HDR_N) begin
            prio_of = (p0 == `N_AUTO_PARAM) ? 4'hC : 4'hA;
        end else if (h > HDR_C) begin
            // C sits between the two N ranks, so only Y, U, L shift by two
            prio_of = 4'(h) + 4'h2;
        end else begin
            prio_of = 4'(h) + 4'h1;
        end
    endfunction

    function automatic logic [3:0] def_of(input hdr_type h);
        unique case (h)
            HDR_A:   def_of = `DEF_A;
            HDR_C:   def_of = `DEF_C;
            HDR_I:   def_of = `DEF_I;
            HDR_K:   def_of = `DEF_K;
            default: def_of = `DEF_OTHER;
        endcase
    endfunction

    assign dec_hdr  = decode(rx_data);
    assign rd_hdr   = hdr_type'(rd_data[13:10]);
    assign rd_np    = rd_data[9:8];
    assign rd_p0    = rd_data[7:4];
    assign rd_p1    = rd_data[3:0];
    assign last_idx = ({1'b0, idx_r} + 1'b1) >= count;
    // native set owns the port unless legacy is selected; eoi unused
    assign rx_ready = legacy_sel && (st_r == ST_IDLE);
    assign take     = rx_valid && rx_ready;

    // byte parser and batch control
    always_comb begin
        pend_nxt = pend_r;
        phdr_nxt = phdr_r;
        pnp_nxt  = pnp_r;
        pp0_nxt  = pp0_r;
        pp1_nxt  = pp1_r;
        berr_nxt = berr_r;
        st_nxt   = st_r;
        prio_nxt = prio_r;
        idx_nxt  = idx_r;
        wr_en    = 1'b0;
        flush    = 1'b0;
        if (take) begin
            if (rx_data >= `CHR_UP_FIRST && rx_data <= `CHR_UP_LAST) begin
                // a new header closes the pending command
                wr_en = pend_r;
                if (pend_r && full) begin
                    berr_nxt = 1'b1;
                end
                pend_nxt = 1'b0;
                phdr_nxt = dec_hdr;
                pnp_nxt  = 2'h0;
                pp0_nxt  = `DEF_OTHER;
                pp1_nxt  = `DEF_OTHER;
                if (dec_hdr == HDR_X) begin
                    if (berr_r || (pend_r && full)) begin
                        flush    = 1'b1;
                        berr_nxt = 1'b0;
                    end else begin
                        st_nxt   = ST_EXEC;
                        prio_nxt = `PRIO_FIRST;
                        idx_nxt  = '0;
                    end
                end else if (dec_hdr == HDR_BAD) begin
                    berr_nxt = 1'b1;
                end else begin
                    pend_nxt = 1'b1;
                end
            end else if (rx_data >= `CHR_DIG_FIRST &&
                         rx_data <= `CHR_DIG_LAST) begin
                if (!pend_r || pnp_r == `PARAM_MAX) begin
                    berr_nxt = 1'b1;
                end else if (pnp_r == 2'h0) begin
                    pp0_nxt = rx_data[3:0];
                    pnp_nxt = 2'h1;
                end else begin
                    pp1_nxt = rx_data[3:0];
                    pnp_nxt = 2'h2;
                end
            end else if (rx_data != `CHR_SPACE && rx_data != `CHR_CR &&
                         rx_data != `CHR_LF && rx_data != `CHR_COMMA) begin
                berr_nxt = 1'b1;
            end
        end
        // scan the store once per rank, oldest entry first
        if (st_r == ST_EXEC) begin
            if (count == '0 || last_idx) begin
                idx_nxt = '0;
                if (prio_r == `PRIO_LAST) begin
                    st_nxt = ST_IDLE;
                    flush  = 1'b1;
                end else begin
                    prio_nxt = prio_r + 4'h1;
                end
            end else begin
                idx_nxt = idx_r + 1'b1;
            end
        end
        if (dev_clear) begin
            pend_nxt = 1'b0;
            berr_nxt = 1'b0;
            if (st_r == ST_IDLE) begin
                flush = 1'b1;
            end
        end
    end

    // issue of a matching entry, defaults filled in
    always_comb begin
        ev_nxt   = 1'b0;
        eh_nxt   = eh_r;
        e0_nxt   = e0_r;
        e1_nxt   = e1_r;
        ec_nxt   = ec_r;
        hold_nxt = hold_r;
        eoi_nxt  = eoi_r;
        uq_nxt   = uq_r;
        // clear first so a fresh query issue in the same cycle wins
        if (query_resp_done) begin
            uq_nxt = 1'b0;
        end
        if (st_r == ST_EXEC && count != '0 &&
            prio_of(rd_hdr, rd_p0) == prio_r) begin
            ev_nxt = 1'b1;
            eh_nxt = rd_hdr;
            e0_nxt = (rd_np == 2'h0) ? def_of(rd_hdr) : rd_p0;
            e1_nxt = (rd_np == `PARAM_MAX) ? rd_p1 : `DEF_OTHER;
            ec_nxt = rd_np;
            if (rd_hdr == HDR_K) begin
                hold_nxt = (e0_nxt <= `K_HOLDOFF_MAX);
                eoi_nxt  = !e0_nxt[0];
            end
            if (rd_hdr == HDR_U && e0_nxt == `U_ERR_PARAM) begin
                uq_nxt = 1'b1;
            end
        end
    end

    // status byte; a set in the clearing cycle wins for bits 6 and 5, the execute clear wins for bit 4
    always_comb begin
        sreq_nxt = sreq_r;
        err_nxt  = err_r;
        rdy_nxt  = rdy_r;
        sp_nxt   = sp_r;
        if (spoll_req || dev_clear) begin
            sreq_nxt = 1'b0;
        end
        if (srq_event) begin
            sreq_nxt = 1'b1;
        end
        if (query_resp_done && uq_r) begin
            err_nxt = 1'b0;
        end
        if (flush && st_r == ST_IDLE && take || exec_error) begin
            err_nxt = 1'b1;
        end
        if (take && dec_hdr == HDR_X) begin
            rdy_nxt = 1'b0;
        end else if (st_r == ST_IDLE && !rdy_r) begin
            rdy_nxt = 1'b1;
        end
        if (spoll_req) begin
            // bits 7,3..1 hard zero; bit 0 tracks overload live
            sp_nxt = 8'h00;
            sp_nxt[`SB_SREQ_BIT] = sreq_r;
            sp_nxt[`SB_ERR_BIT] = err_r;
            sp_nxt[`SB_RDY_BIT] = rdy_r;
            sp_nxt[`SB_OVL_BIT] = overload;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pend_r <= 1'b0;
            phdr_r <= HDR_BAD;
            pnp_r  <= 2'h0;
            pp0_r  <= 4'h0;
            pp1_r  <= 4'h0;
            berr_r <= 1'b0;
            st_r   <= ST_IDLE;
            prio_r <= 4'h1;
            idx_r  <= '0;
            ev_r   <= 1'b0;
            eh_r   <= HDR_BAD;
            e0_r   <= 4'h0;
            e1_r   <= 4'h0;
            ec_r   <= 2'h0;
            hold_r <= 1'b1;
            eoi_r  <= 1'b1;
            uq_r   <= 1'b0;
            sreq_r <= 1'b0;
            err_r  <= 1'b0;
            rdy_r  <= 1'b1;
            sp_r   <= 8'h00;
        end else begin
            pend_r <= pend_nxt;
            phdr_r <= phdr_nxt;
            pnp_r  <= pnp_nxt;
            pp0_r  <= pp0_nxt;
            pp1_r  <= pp1_nxt;
            berr_r <= berr_nxt;
            st_r   <= st_nxt;
            prio_r <= prio_nxt;
            idx_r  <= idx_nxt;
            ev_r   <= ev_nxt;
            eh_r   <= eh_nxt;
            e0_r   <= e0_nxt;
            e1_r   <= e1_nxt;
            ec_r   <= ec_nxt;
            hold_r <= hold_nxt;
            eoi_r  <= eoi_nxt;
            uq_r   <= uq_nxt;
            sreq_r <= sreq_nxt;
            err_r  <= err_nxt;
            rdy_r  <= rdy_nxt;
            sp_r   <= sp_nxt;
        end
    end

    // request line exists only on the parallel bus side
    assign srq_line    = sreq_r;
    assign nrfd_hold   = hold_r && (st_r == ST_EXEC);
    assign spoll_data  = sp_r;
    assign exec_valid  = ev_r;
    assign exec_hdr    = eh_r;
    assign exec_param0 = e0_r;
    assign exec_param1 = e1_r;
    assign exec_count  = ec_r;
    assign eoi_append  = eoi_r;
    assign busy        = (st_r == ST_EXEC);
endmodule

// >>> bench/legacy_command_status_unit_sva.sv
`timescale 1ns/1ps
module legacy_command_status_unit_sva
    import legacy_cmd_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       legacy_sel,
    input wire logic       rx_ready,
    input wire logic       spoll_req,
    input wire logic [7:0] spoll_data,
    input wire logic       dev_clear,
    input wire logic       srq_event,
    input wire logic       srq_line,
    input wire logic       overload,
    input wire logic       exec_valid,
    input wire hdr_type    exec_hdr,
    input wire logic [1:0] exec_count,
    input wire logic       nrfd_hold,
    input wire logic       busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // status byte as seen by the poller
    chk_unused_bits_zero: assert property (spoll_data[7] == 1'b0
        && spoll_data[3:1] == 3'h0) else $error("unused bit set");
    chk_srq_sets_line: assert property (srq_event && !dev_clear
        |-> ##[1:2] srq_line) else $error("request not raised");
    chk_poll_clears_srq: assert property (spoll_req && !srq_event
        ##1 !srq_event |-> ##[0:1] !srq_line) else $error("poll kept srq");
    chk_dclr_clears_srq: assert property (dev_clear && !srq_event
        ##1 !srq_event |-> ##[0:1] !srq_line) else $error("clear kept srq");
    chk_ready_bit_busy: assert property (busy && spoll_req
        |=> !spoll_data[4]) else $error("ready bit during batch");
    chk_overload_follow: assert property (spoll_req
        |=> spoll_data[0] == $past(overload)) else $error("overload bit");
    // byte port and batch execution
    chk_rx_gate_closed: assert property (!legacy_sel || busy
        |-> !rx_ready) else $error("bytes taken while closed");
    chk_exec_in_batch: assert property (exec_valid
        |-> busy || $past(busy)) else $error("command run outside batch");
    chk_exec_hdr_known: assert property (exec_valid
        |-> exec_hdr != HDR_X && exec_hdr != HDR_BAD && exec_count <= 2'h2)
        else $error("bad command issued");
    chk_hold_in_batch: assert property (nrfd_hold
        |-> busy && !rx_ready) else $error("hold while accepting");

    cover property (exec_valid);
    cover property ($rose(srq_line));
    cover property (busy && nrfd_hold);
endmodule

// >>> bench/host_bus_model.sv
`timescale 1ns/1ps
// host controller offering command bytes one at a time
module host_bus_model (
    input  wire logic       clock,
    input  wire logic       rx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_eoi
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'hA5;
        rx_eoi = 1'b0;
    end

    // holds the byte until taken; eoi is random as the unit ignores it
    task automatic send_byte(input logic [7:0] b, input logic e);
        logic r;
        rx_valid = 1'b1;
        rx_data = b;
        rx_eoi = e;
        r = 1'b0;
        while (!r) begin
            @(negedge clock);
            r = rx_ready;
            @(posedge clock);
        end
        #1;
        rx_valid = 1'b0;
        rx_data = ~b; // released bus shows no stale byte
        rx_eoi = ~e;
        // idle edge so the next byte never re-raises valid at once
        @(posedge clock);
        #1;
    endtask

    // string sent byte by byte in order; no execute letter appended
    task automatic send_str(input string s, input logic [31:0] m);
        for (int i = 0; i < s.len(); i++) begin
            send_byte(s[i], m[i%32]);
        end
    endtask
endmodule

// >>> bench/test_legacy_command_status_unit.sv
`timescale 1ns/1ps
module test_legacy_command_status_unit;
    import legacy_cmd_pkg::*;
    logic       clock = 1'b0;
    logic       rstn = 1'b0;
    logic       legacy_sel = 1'b1;
    logic       spoll_req = 1'b0;
    logic       dev_clear = 1'b0;
    logic       srq_event = 1'b0;
    logic       exec_error = 1'b0;
    logic       query_resp_done = 1'b0;
    logic       overload = 1'b0;
    logic       poll_pend = 1'b0;
    logic       rx_valid, rx_ready, rx_eoi, nrfd_hold, srq_line;
    logic       exec_valid, eoi_append, busy;
    logic [7:0] rx_data, spoll_data;
    logic [3:0] exec_param0, exec_param1, z, m;
    logic [1:0] exec_count;
    hdr_type    exec_hdr;
    logic [13:0] exq[$];
    logic [7:0] pq[$];
    int         fails = 0;
    int         check_count = 0;
    int         seed = 32'h108C9516;
    int         i;
    string      bad[8] = '{"A2B", "D", "H", "J", "V", "W", "A123", "7"};
    string      all_hdr = "MKAIRTPZSNCYUL";

    always #10 clock = ~clock;

    legacy_command_status_unit #(.DEPTH(16)) legacy_command_status_unit_inst (
        .clock(clock), .rstn(rstn), .legacy_sel(legacy_sel),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_eoi(rx_eoi), .nrfd_hold(nrfd_hold), .spoll_req(spoll_req),
        .spoll_data(spoll_data), .dev_clear(dev_clear),
        .srq_event(srq_event), .srq_line(srq_line),
        .exec_error(exec_error), .query_resp_done(query_resp_done),
        .overload(overload), .exec_valid(exec_valid),
        .exec_hdr(exec_hdr), .exec_param0(exec_param0),
        .exec_param1(exec_param1), .exec_count(exec_count),
        .eoi_append(eoi_append), .busy(busy));

    host_bus_model host_bus_model_inst (.clock(clock),
        .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_eoi(rx_eoi));

    task automatic check(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask

    task automatic ex(input hdr_type h, input logic [3:0] p,
                      input logic [1:0] n, input logic [3:0] q = 4'h0);
        exq.push_back({h, p, n, q});
    endtask

    task automatic send(input string s);
        host_bus_model_inst.send_str(s, $random(seed));
    endtask

    // one-cycle strobe, result read by the monitor
    task automatic poll(input logic [7:0] e);
        spoll_req = 1'b1;
        @(posedge clock);
        #1;
        spoll_req = 1'b0;
        pq.push_back(e);
        poll_pend = 1'b1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge clock);
        #1;
        s = 1'b0;
    endtask

    // bounded wait for the batch scan to finish
    task automatic run_wait;
        int n;
        n = 0;
        repeat (2) @(posedge clock);
        #1;
        if (busy === 1'b1) check(nrfd_hold === 1'b1, "no hold");
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clock);
            n++;
        end
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic clear_err;
        ex(HDR_U, 1, 1);
        send("U1X");
        run_wait;
        pulse(query_resp_done);
        poll(8'h10);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // oldest note against each issued command and each poll result
    always @(negedge clock) begin
        if (exec_valid === 1'b1) begin
            if (exq.size() == 0) check(1'b0, "extra command");
            else check({exec_hdr, exec_param0, exec_count, exec_param1}
                       === exq.pop_front(), "command");
        end
        if (poll_pend) begin
            poll_pend = 1'b0;
            check(spoll_data === pq.pop_front(), "status");
        end
    end

    initial begin
        #400000;
        fails++;
        $display("[ERR] %0t watchdog", $time);
        finish_test;
    end

    initial begin
        repeat (10) @(posedge clock);
        #1;
        rstn = 1'b1;
        poll(8'h10);
        // reordered batch, N2 lower rank, N1/N0 kept in arrival order
        z = 4'({$random(seed)} % 10);
        m = 4'({$random(seed)} % 10);
        send($sformatf("L0Z%0dM%0dN2K0N1N0C0", z, m));
        repeat (40) @(posedge clock);
        #1;
        poll(8'h10);
        ex(HDR_M, m, 1);
        ex(HDR_K, 0, 1);
        ex(HDR_Z, z, 1);
        ex(HDR_N, 1, 1);
        ex(HDR_N, 0, 1);
        ex(HDR_C, 0, 1);
        ex(HDR_N, 2, 1);
        ex(HDR_L, 0, 1);
        send("X");
        poll(8'h00);
        run_wait;
        poll(8'h10);
        $display("priority test done");
        // every header bare, sent lowest rank first; A and C default 1
        for (i = 0; i < 14; i++) ex(hdr_type'(i), 4'(i == 2 || i == 10), 0);
        for (i = 13; i >= 0; i--) send(all_hdr.substr(i, i));
        send("X");
        run_wait;
        ex(HDR_L, 0, 1);
        ex(HDR_Z, 0, 1);
        ex(HDR_K, 1, 1);
        ex(HDR_S, 1, 2, 2);
        send("L0XZ0XK1S12X");
        run_wait;
        check(eoi_append === 1'b0, "eoi kept");
        $display("header test done");
        // faulty batches are dropped whole and flag an error
        foreach (bad[k]) begin
            send({bad[k], "X"});
            run_wait;
            poll(8'h30);
            clear_err;
        end
        pulse(exec_error);
        pulse(query_resp_done);
        poll(8'h30);
        clear_err;
        $display("error test done");
        // service request, overload, device clear
        overload = 1'b1;
        pulse(srq_event);
        poll(8'h51);
        @(posedge clock);
        #1;
        poll(8'h11);
        overload = 1'b0;
        pulse(srq_event);
        pulse(dev_clear);
        poll(8'h10);
        legacy_sel = 1'b0;
        #5;
        check(rx_ready === 1'b0, "port open");
        legacy_sel = 1'b1;
        @(posedge clock);
        #1;
        rstn = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rstn = 1'b1;
        poll(8'h10);
        repeat (3) @(posedge clock);
        check(eoi_append === 1'b1, "eoi reset value");
        check(exq.size() == 0 && pq.size() == 0, "lost results");
        $display("status test done");
        finish_test;
    end
endmodule

bind legacy_command_status_unit legacy_command_status_unit_sva #(
    .DEPTH(DEPTH)) sva_inst (.clock(clock), .rstn(rstn),
    .legacy_sel(legacy_sel), .rx_ready(rx_ready), .spoll_req(spoll_req),
    .spoll_data(spoll_data), .dev_clear(dev_clear),
    .srq_event(srq_event), .srq_line(srq_line), .overload(overload),
    .exec_valid(exec_valid), .exec_hdr(exec_hdr),
    .exec_count(exec_count), .nrfd_hold(nrfd_hold), .busy(busy));
